// [core/fhar_pkg.sv]
// Package for the fault history and automatic retry block
package fhar_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] OFS_PRESENT = 8'h00;
   localparam logic [7:0] OFS_PREV1 = 8'h04;
   localparam logic [7:0] OFS_PREV2 = 8'h08;
   localparam logic [7:0] OFS_PREV3 = 8'h0c;
   localparam logic [7:0] OFS_LIMIT = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_COUNT = 8'h24;
   // ==========================================
   // Field positions and values
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_RST_BIT = 1;
   localparam int ST_TRIP_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_PEND_BIT = 2;
   localparam int IRQ_TRIP_BIT = 0;
   localparam int IRQ_AUTO_BIT = 1;
   localparam int IRQ_LOCK_BIT = 2;
   localparam logic [7:0] LIMIT_MAX = 8'h0a;
   localparam logic [7:0] LIMIT_RESET = 8'h00;
   localparam logic [4:0] CODE_MAX = 5'h14;
   localparam logic [2:0] DI_FUNC_RESET = 3'h2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // ==========================================
   // Fault codes
   localparam logic [4:0] CODE_NONE = 5'h00;
   localparam logic [4:0] CODE_PANEL_COMM = 5'h00;
   localparam logic [4:0] CODE_STANDBY_OVI = 5'h01;
   localparam logic [4:0] CODE_ACCEL_OVI = 5'h02;
   localparam logic [4:0] CODE_DECEL_OVI = 5'h03;
   localparam logic [4:0] CODE_STEADY_OVI = 5'h04;
   localparam logic [4:0] CODE_EXT_FAULT = 5'h05;
   localparam logic [4:0] CODE_BUS_OV = 5'h06;
   localparam logic [4:0] CODE_BUS_UV = 5'h07;
   localparam logic [4:0] CODE_THERMAL = 5'h08;
   localparam logic [4:0] CODE_TUNE_FAIL = 5'h0a;
   localparam logic [4:0] CODE_PARAM_RANGE = 5'h10;
   // ==========================================
   // Timing
   localparam longint CLK_HZ = 20000000;
   localparam longint RETRY_WAIT_S = 6;
   localparam longint RETRY_WAIT_CYC = RETRY_WAIT_S * CLK_HZ;
   // ==========================================
   // Types
   typedef enum logic [1:0]
   {
      PH_STANDBY = 2'b00,
      PH_ACCEL = 2'b01,
      PH_STEADY = 2'b11,
      PH_DECEL = 2'b10
   } fhar_phase_type;
   typedef enum logic [1:0]
   {
      ST_CLEAR = 2'b00,
      ST_WAIT = 2'b01,
      ST_HOLD = 2'b11
   } fhar_state_type;
   typedef struct packed
   {
      logic panel_comm_fail;
      logic over_voltage;
      logic over_current;
      logic ext_fault;
      logic bus_ov;
      logic bus_uv;
      logic thermal;
      logic tune_fail;
      logic param_range;
   } fhar_fault_type;
   typedef struct packed
   {
      logic [4:0] code;
      logic sub_current;
   } fhar_entry_type;
endpackage

// [core/fhar_core.sv]
// Fault history, trip encoding and automatic retry with AXI4-Lite registers
`timescale 1ns/100ps
module fhar_core
   import fhar_pkg::*;
#(
   parameter longint RETRY_CYCLES = RETRY_WAIT_CYC
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Fault detectors and drive state
   input wire fhar_fault_type fault_in,
   input wire fhar_phase_type phase_in,
   // Manual reset sources
   input wire logic panel_reset_btn,
   input wire logic [2:0] digital_input_terminal,
   // Drive control outputs
   output logic tripped,
   output logic restart_pulse,
   output logic continue_pulse,
   output logic irq,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ==========================================
   // Declarations
   fhar_entry_type hist_r [4];
   fhar_state_type state_r;
   logic [7:0] limit_r;
   logic [3:0] count_r;
   logic run_src_r;
   logic [27:0] timer_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [2:0] din_s1_r;
   logic [2:0] din_s2_r;
   logic btn_s1_r;
   logic btn_s2_r;
   logic manual_prev_r;
   fhar_fault_type flt_s1_r;
   fhar_fault_type flt_s2_r;
   fhar_fault_type flt_prev_r;
   logic trip_run_r;
   logic [7:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   logic manual_lvl;
   logic manual_evt;
   logic soft_reset;
   logic new_trip;
   logic auto_clear;
   logic lock_evt;
   logic wr_fire;
   fhar_entry_type trip_entry;
   fhar_fault_type flt_rise;

   // ==========================================
   // Trip encoder, lowest code wins
   function automatic fhar_entry_type encode(input fhar_fault_type f, input fhar_phase_type p);
      fhar_entry_type e;
      e.code = CODE_NONE;
      e.sub_current = 1'b0;
      if (f.panel_comm_fail)
         e.code = CODE_PANEL_COMM;
      else if (f.over_voltage || f.over_current)
      begin
         e.sub_current = f.over_current && !f.over_voltage;
         case (p)
            PH_STANDBY: e.code = CODE_STANDBY_OVI;
            PH_ACCEL: e.code = CODE_ACCEL_OVI;
            PH_DECEL: e.code = CODE_DECEL_OVI;
            PH_STEADY: e.code = CODE_STEADY_OVI;
            default: e.code = CODE_STEADY_OVI;
         endcase
      end
      else if (f.ext_fault)
         e.code = CODE_EXT_FAULT;
      else if (f.bus_ov)
         e.code = CODE_BUS_OV;
      else if (f.bus_uv)
         e.code = CODE_BUS_UV;
      else if (f.thermal)
         e.code = CODE_THERMAL;
      else if (f.tune_fail)
         e.code = CODE_TUNE_FAIL;
      else if (f.param_range)
         e.code = CODE_PARAM_RANGE;
      return e;
   endfunction

   // ==========================================
   // Input synchronisers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         din_s1_r <= 3'h0;
         din_s2_r <= 3'h0;
         btn_s1_r <= 1'b0;
         btn_s2_r <= 1'b0;
         flt_s1_r <= '0;
         flt_s2_r <= '0;
         flt_prev_r <= '0;
         manual_prev_r <= 1'b0;
      end
      else
      begin
         din_s1_r <= digital_input_terminal;
         din_s2_r <= din_s1_r;
         btn_s1_r <= panel_reset_btn;
         btn_s2_r <= btn_s1_r;
         flt_s1_r <= fault_in;
         flt_s2_r <= flt_s1_r;
         flt_prev_r <= flt_s2_r;
         manual_prev_r <= manual_lvl;
      end
   end

   assign flt_rise = flt_s2_r & ~flt_prev_r;
   assign manual_lvl = btn_s2_r || (din_s2_r == DI_FUNC_RESET);
   assign manual_evt = (manual_lvl && !manual_prev_r) || soft_reset;
   assign trip_entry = encode(flt_s2_r, phase_in);
   assign new_trip = (flt_rise != '0) && (state_r == ST_CLEAR);
   assign auto_clear = (state_r == ST_WAIT) && (timer_r == 28'(RETRY_CYCLES - 1)) && !manual_evt;
   assign lock_evt = new_trip && (!trip_run_r || {4'h0, count_r} >= limit_r);

   // ==========================================
   // Fault history
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 4; i++)
            hist_r[i] <= '0;
      end
      else if (new_trip)
      begin
         for (int i = 3; i > 0; i--)
            hist_r[i] <= hist_r[i-1];
         hist_r[0] <= trip_entry;
      end
   end

   // ==========================================
   // Retry state machine
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         trip_run_r <= 1'b0;
      else
         trip_run_r <= (phase_in != PH_STANDBY);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= ST_CLEAR;
         timer_r <= 28'h0;
         count_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            ST_CLEAR:
               if (new_trip)
               begin
                  timer_r <= 28'h0;
                  if (count_r != 4'hf)
                     count_r <= count_r + 4'h1;
                  if (lock_evt)
                     state_r <= ST_HOLD;
                  else
                     state_r <= ST_WAIT;
               end
               else if (manual_evt)
                  count_r <= 4'h0;
            ST_WAIT:
               if (manual_evt)
               begin
                  state_r <= ST_CLEAR;
                  count_r <= 4'h0;
               end
               else if (auto_clear)
                  state_r <= ST_CLEAR;
               else
                  timer_r <= timer_r + 28'h1;
            ST_HOLD:
               if (manual_evt)
               begin
                  state_r <= ST_CLEAR;
                  count_r <= 4'h0;
               end
            default: state_r <= ST_CLEAR;
         endcase
      end
   end

   // Auto clear restarts or continues per run source
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         restart_pulse <= 1'b0;
         continue_pulse <= 1'b0;
      end
      else
      begin
         restart_pulse <= auto_clear && !run_src_r;
         continue_pulse <= auto_clear && run_src_r;
      end
   end

   assign tripped = (state_r != ST_CLEAR);
   assign irq = |(irq_stat_r & irq_mask_r);

   // ==========================================
   // AXI4-Lite write path
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
   assign soft_reset = wr_fire && (aw_addr_r == OFS_CTRL) && w_strb_r[0] &&
      w_data_r[CTRL_RST_BIT];

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
               OFS_PRESENT, OFS_PREV1, OFS_PREV2, OFS_PREV3, OFS_STATUS, OFS_COUNT,
               OFS_LIMIT, OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK: s_axi_bresp <= AXI_OKAY;
               default: s_axi_bresp <= AXI_SLVERR;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         limit_r <= LIMIT_RESET;
         run_src_r <= 1'b0;
         irq_mask_r <= 3'h0;
      end
      else if (wr_fire && w_strb_r[0])
      begin
         if (aw_addr_r == OFS_LIMIT)
            limit_r <= (w_data_r[7:0] > LIMIT_MAX) ? LIMIT_MAX : w_data_r[7:0];
         if (aw_addr_r == OFS_CTRL)
            run_src_r <= w_data_r[CTRL_SRC_BIT];
         if (aw_addr_r == OFS_IRQ_MASK)
            irq_mask_r <= w_data_r[2:0];
      end
   end

   // Sticky events, set wins over write-one-to-clear
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq_stat_r <= 3'h0;
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (wr_fire && aw_addr_r == OFS_IRQ_STAT && w_strb_r[0] && w_data_r[i])
               irq_stat_r[i] <= 1'b0;
         end
         if (new_trip)
            irq_stat_r[IRQ_TRIP_BIT] <= 1'b1;
         if (auto_clear)
            irq_stat_r[IRQ_AUTO_BIT] <= 1'b1;
         if (lock_evt)
            irq_stat_r[IRQ_LOCK_BIT] <= 1'b1;
      end
   end

   // ==========================================
   // AXI4-Lite read path
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= AXI_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= AXI_OKAY;
         s_axi_rdata <= 32'h0;
         case ({s_axi_araddr[7:2], 2'b00})
            OFS_PRESENT: s_axi_rdata <= {23'h0, hist_r[0].sub_current, 3'h0, hist_r[0].code};
            OFS_PREV1: s_axi_rdata <= {23'h0, hist_r[1].sub_current, 3'h0, hist_r[1].code};
            OFS_PREV2: s_axi_rdata <= {23'h0, hist_r[2].sub_current, 3'h0, hist_r[2].code};
            OFS_PREV3: s_axi_rdata <= {23'h0, hist_r[3].sub_current, 3'h0, hist_r[3].code};
            OFS_LIMIT: s_axi_rdata <= {24'h0, limit_r};
            OFS_CTRL: s_axi_rdata <= {31'h0, run_src_r};
            OFS_STATUS: s_axi_rdata <= {29'h0, state_r == ST_WAIT, state_r == ST_HOLD, tripped};
            OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_r};
            OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_r};
            OFS_COUNT: s_axi_rdata <= {28'h0, count_r};
            default: s_axi_rresp <= AXI_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule

// [verif/fhar_panel_model.sv]
// Operator panel, input terminal and fault detector model
`timescale 1ns/100ps
module fhar_panel_model
   import fhar_pkg::*;
#(
   parameter int PRESS_CYC = 3
)
(
   // Clock
   input wire logic core_clk,
   // Requests from the bench
   input wire logic [8:0] fault_req,
   input wire logic btn_req,
   input wire logic di_req,
   // Lines toward the block
   output fhar_fault_type fault_in,
   output logic panel_reset_btn,
   output logic [2:0] digital_input_terminal
);
   logic [7:0] btn_cnt_r = 8'h00;
   logic [7:0] di_cnt_r = 8'h00;

   // Detectors hold their level as long as the condition lasts
   assign fault_in = fhar_fault_type'(fault_req);

   // A press lasts several cycles, as a human or a terminal would give it
   always_ff @(posedge core_clk)
   begin
      if (btn_req)
         btn_cnt_r <= 8'(PRESS_CYC);
      else if (btn_cnt_r != 8'h00)
         btn_cnt_r <= btn_cnt_r - 8'h01;
   end

   always_ff @(posedge core_clk)
   begin
      if (di_req)
         di_cnt_r <= 8'(PRESS_CYC);
      else if (di_cnt_r != 8'h00)
         di_cnt_r <= di_cnt_r - 8'h01;
   end

   assign panel_reset_btn = (btn_cnt_r != 8'h00);
   assign digital_input_terminal = (di_cnt_r != 8'h00) ? DI_FUNC_RESET : 3'h0;
endmodule

// [verif/fhar_checker.sv]
// Concurrent checks on the fault history block ports
`timescale 1ns/100ps
module fhar_checker
   import fhar_pkg::*;
#(
   parameter longint RETRY_CYCLES = 20
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Trip path
   input wire fhar_fault_type fault_in,
   input wire logic panel_reset_btn,
   input wire logic tripped,
   input wire logic restart_pulse,
   input wire logic continue_pulse,
   // Register bus
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   localparam longint MIN_WAIT = RETRY_CYCLES - 1;
   logic [31:0] len_r;
   logic was_r;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // ==========================================
   // Length of the last trip in cycles
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         len_r <= 32'h0;
         was_r <= 1'b0;
      end
      else
      begin
         if (tripped)
            len_r <= was_r ? len_r + 32'h1 : 32'h1;
         was_r <= tripped;
      end
   end

   sequence s_new_fault;
      !tripped && !panel_reset_btn && $past(fault_in) == 9'h0 && fault_in != 9'h0;
   endsequence
   sequence s_press;
      $rose(panel_reset_btn);
   endsequence

   // ==========================================
   chk_trip_latency: assert property (s_new_fault |=> !tripped [*2] ##1 tripped)
      else $error("trip latency wrong");
   chk_manual_clear: assert property (s_press |-> ##[1:6] !tripped)
      else $error("manual reset did not clear");
   chk_auto_wait: assert property ((restart_pulse || continue_pulse) |-> len_r >= MIN_WAIT)
      else $error("auto clear too early");
   chk_pulse_after: assert property (restart_pulse |-> !tripped && ($past(tripped) || $past(tripped, 2)))
      else $error("restart without clear");
   chk_pulse_shape: assert property ((restart_pulse || continue_pulse) |->
      !(restart_pulse && continue_pulse) ##1 !(restart_pulse || continue_pulse))
      else $error("pulse shape wrong");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");
endmodule

bind fhar_core fhar_checker #(.RETRY_CYCLES(RETRY_CYCLES)) u_fhar_checker
(
   .core_clk(core_clk),
   .resetn(resetn),
   .fault_in(fault_in),
   .panel_reset_btn(panel_reset_btn),
   .tripped(tripped),
   .restart_pulse(restart_pulse),
   .continue_pulse(continue_pulse),
   .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata)
);

// [verif/testbench.sv]
// Self-checking bench for the fault history block
`timescale 1ns/100ps
module testbench
   import fhar_pkg::*;
;
   logic core_clk = 1'b0;
   logic resetn;
   logic [8:0] fault_req;
   logic btn_req, di_req, panel_reset_btn, tripped, restart_pulse, continue_pulse, irq;
   logic [2:0] dit;
   fhar_fault_type fault_in;
   fhar_phase_type ph;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   int err_count, checked, cyc, rs_cnt, ct_cnt;
   logic [8:0] row_mask [11] = '{9'h100, 9'h080, 9'h040, 9'h080, 9'h040, 9'h020, 9'h010,
      9'h008, 9'h004, 9'h002, 9'h001};
   fhar_phase_type row_ph [11] = '{PH_STANDBY, PH_STANDBY, PH_ACCEL, PH_DECEL, PH_STEADY,
      PH_STANDBY, PH_STANDBY, PH_STANDBY, PH_STANDBY, PH_STANDBY, PH_STANDBY};
   logic [31:0] row_exp [11] = '{32'h0, 32'h1, 32'h102, 32'h3, 32'h104, 32'h5, 32'h6, 32'h7,
      32'h8, 32'ha, 32'h10};

   always #25 core_clk = ~core_clk;

   fhar_core #(.RETRY_CYCLES(20)) u_fhar_core
   (
      .core_clk(core_clk), .resetn(resetn), .fault_in(fault_in), .phase_in(ph),
      .panel_reset_btn(panel_reset_btn), .digital_input_terminal(dit), .tripped(tripped),
      .restart_pulse(restart_pulse), .continue_pulse(continue_pulse), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   fhar_panel_model #(.PRESS_CYC(3)) u_fhar_panel_model
   (
      .core_clk(core_clk), .fault_req(fault_req), .btn_req(btn_req), .di_req(di_req),
      .fault_in(fault_in), .panel_reset_btn(panel_reset_btn), .digital_input_terminal(dit)
   );

   task test_done;
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      int n;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      tb = 1'b0;
      while (!tb && n < 50)
      begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         r = bresp;
         n++;
         @(posedge core_clk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
            bready <= 1'b0;
      end
      if (!tb)
         err_count++;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
      logic ta, tb;
      int n;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      tb = 1'b0;
      while (!tb && n < 50)
      begin
         @(negedge core_clk);
         ta = arvalid && arready;
         tb = rvalid && rready;
         v = rdata;
         s = rresp;
         n++;
         @(posedge core_clk);
         if (ta)
            arvalid <= 1'b0;
         if (tb)
            rready <= 1'b0;
      end
      if (!tb)
         err_count++;
   endtask

   task wait_trip(input logic lv);
      int n;
      n = 0;
      while (tripped !== lv && n < 100)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("tripped", 32'(lv), 32'(tripped));
   endtask

   task trip(input logic [8:0] m);
      @(posedge core_clk);
      fault_req <= m;
      wait_trip(1'b1);
      @(posedge core_clk);
      fault_req <= 9'h0;
   endtask

   task manual(input logic use_di);
      @(posedge core_clk);
      if (use_di)
         di_req <= 1'b1;
      else
         btn_req <= 1'b1;
      @(posedge core_clk);
      di_req <= 1'b0;
      btn_req <= 1'b0;
      wait_trip(1'b0);
   endtask

   always @(negedge core_clk)
   begin
      cyc++;
      if (restart_pulse === 1'b1)
         rs_cnt++;
      if (continue_pulse === 1'b1)
         ct_cnt++;
      if (cyc == 20000)
      begin
         err_count++;
         test_done;
      end
   end

   initial
   begin
      resetn = 1'b0;
      {fault_req, btn_req, di_req, awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hf;
      ph = PH_STANDBY;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      for (int k = 0; k < 10; k++)
      begin
         rd(8'(k * 4), d, r);
         chk("reset value", 32'h0, d);
      end
      wr(OFS_LIMIT, 32'h0f);
      rd(OFS_LIMIT, d, r);
      chk("limit", 32'h0a, d);
      rd(8'h40, d, r);
      chk("unmapped resp", 32'(AXI_SLVERR), 32'(r));
      chk("unmapped data", 32'h0, d);
      wr(8'h40, 32'h1);
      chk("unmapped wr resp", 32'(AXI_SLVERR), 32'(r));
      wr(OFS_LIMIT, 32'h0);
      chk("write resp", 32'(AXI_OKAY), 32'(r));
      for (int i = 0; i < 11; i++)
      begin
         @(posedge core_clk);
         ph <= row_ph[i];
         trip(row_mask[i]);
         rd(OFS_PRESENT, d, r);
         chk("present", row_exp[i], d);
         rd(OFS_STATUS, d, r);
         chk("status", 32'h3, d);
         manual(i[0]);
      end
      rd(OFS_PREV1, d, r);
      chk("previous", 32'ha, d);
      rd(OFS_PREV2, d, r);
      chk("second prior", 32'h8, d);
      rd(OFS_PREV3, d, r);
      chk("third prior", 32'h7, d);
      wr(OFS_LIMIT, 32'h2);
      ph <= PH_ACCEL;
      for (int j = 0; j < 3; j++)
      begin
         trip(9'h020);
         rd(OFS_STATUS, d, r);
         chk("pending", (j < 2) ? 32'h5 : 32'h3, d);
         repeat (40) @(negedge core_clk);
         chk("held", 32'(j == 2), 32'(tripped));
         chk("restarts", (j < 2) ? j + 1 : 2, rs_cnt);
      end
      rd(OFS_COUNT, d, r);
      chk("count", 32'h3, d);
      manual(1'b0);
      rd(OFS_COUNT, d, r);
      chk("count cleared", 32'h0, d);
      wr(OFS_CTRL, 32'h1);
      trip(9'h004);
      repeat (40) @(negedge core_clk);
      chk("continues", 32'h1, ct_cnt);
      wr(OFS_IRQ_MASK, 32'h1);
      wr(OFS_IRQ_STAT, 32'h7);
      chk("irq idle", 32'h0, 32'(irq));
      ph <= PH_STANDBY;
      trip(9'h010);
      repeat (40) @(negedge core_clk);
      chk("standby held", 32'h1, 32'(tripped));
      chk("irq raised", 32'h1, 32'(irq));
      wr(OFS_IRQ_STAT, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq));
      manual(1'b1);
      trip(9'h010);
      wr(OFS_CTRL, 32'h3);
      chk("soft reset", 32'h0, 32'(tripped));
      rd(OFS_CTRL, d, r);
      chk("ctrl", 32'h1, d);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      rd(OFS_PRESENT, d, r);
      chk("second reset", 32'h0, d);
      test_done;
   end
endmodule
